// ---- pcs_flow_ctrl.sv ----
// Program counter, return stack control, interrupt control and reset cause
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`include "pcs_regs.svh"
module pcs_flow_ctrl #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exec_advance,
  input wire logic exec_call,
  input wire logic exec_jump,
  input wire logic [10:0] exec_target,
  input wire logic exec_return,
  input wire logic exec_irq_branch,
  input wire logic timer_zero_overflow,
  input wire logic ext_pin_edge,
  input wire logic port_change,
  input wire logic ext_reset_pin_req,
  input wire logic watchdog_timer_req,
  output logic [12:0] pc,
  output logic irq_request
);
  logic [12:0] pc_reg;
  logic [7:0] pc_high_latch_reg;
  logic [7:0] irq_ctrl_reg;
  logic [7:0] irq_ctrl_next;
  logic [7:0] reset_cause_reg;
  logic por_done_reg = 1'b0;
  pcs_pkg::pcs_wr_state_t wr_state_reg;
  logic [11:0] aw_addr_reg;
  logic aw_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_held_reg;
  logic wr_fire;
  logic wr_hit;
  logic [7:0] wr_byte;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic pc_low_wr;
  logic pc_high_wr;
  logic irq_wr;
  logic cause_wr;
  logic irq_sync1_reg;
  logic irq_sync2_reg;
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic port_sync1_reg;
  logic port_sync2_reg;
  logic rpin_sync1_reg;
  logic rpin_sync2_reg;
  logic wdt_sync1_reg;
  logic wdt_sync2_reg;
  logic do_push;
  logic do_pop;

  pcs_stack_if #(.AW(13)) stk ();

  pcs_return_stack #(.DEPTH(STACK_DEPTH), .AW(13)) u_stack (
    .aclk(aclk),
    .aresetn(aresetn),
    .sp(stk)
  );

  // ----------------------------------------
  // Event input synchronisers
  // ----------------------------------------
  // Event sources come from pins or other domains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sync1_reg <= 1'b0;
      irq_sync2_reg <= 1'b0;
    end else begin
      irq_sync1_reg <= timer_zero_overflow;
      irq_sync2_reg <= irq_sync1_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
    end else begin
      ext_sync1_reg <= ext_pin_edge;
      ext_sync2_reg <= ext_sync1_reg;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_sync1_reg <= 1'b0;
      port_sync2_reg <= 1'b0;
    end else begin
      port_sync1_reg <= port_change;
      port_sync2_reg <= port_sync1_reg;
    end
  end

  // Reset requests must survive the bus reset, so they sync without it
  always_ff @(posedge aclk) begin
    rpin_sync1_reg <= ext_reset_pin_req;
    rpin_sync2_reg <= rpin_sync1_reg;
  end

  always_ff @(posedge aclk) begin
    wdt_sync1_reg <= watchdog_timer_req;
    wdt_sync2_reg <= wdt_sync1_reg;
  end

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign s_axi_awready = !aw_held_reg && (wr_state_reg == pcs_pkg::PCS_WR_IDLE);
  assign s_axi_wready = !w_held_reg && (wr_state_reg == pcs_pkg::PCS_WR_IDLE);
  assign wr_fire = aw_held_reg && w_held_reg && (wr_state_reg == pcs_pkg::PCS_WR_IDLE);
  assign wr_byte = w_data_reg[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    pc_low_wr = 1'b0;
    pc_high_wr = 1'b0;
    irq_wr = 1'b0;
    cause_wr = 1'b0;
    wr_hit = 1'b1;
    // Decoded by word index, so every register owns a whole word
    case (aw_addr_reg[11:2])
      `PCS_OFS_PC_LOW: pc_low_wr = wr_fire && w_strb_reg[0];
      `PCS_OFS_PC_HIGH_LATCH: pc_high_wr = wr_fire && w_strb_reg[0];
      `PCS_OFS_IRQ_CTRL: irq_wr = wr_fire && w_strb_reg[0];
      `PCS_OFS_IRQ_CTRL_ALT: irq_wr = wr_fire && w_strb_reg[0];
      `PCS_OFS_RESET_CAUSE: cause_wr = wr_fire && w_strb_reg[0];
      `PCS_OFS_PC_STATUS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= pcs_pkg::PCS_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      case (wr_state_reg)
        pcs_pkg::PCS_WR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= pcs_pkg::PCS_WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
          end
        end
        pcs_pkg::PCS_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= pcs_pkg::PCS_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state_reg <= pcs_pkg::PCS_WR_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Stack and pointer have no address at all
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr[11:2])
      `PCS_OFS_PC_LOW: rd_byte = pc_reg[7:0];
      `PCS_OFS_PC_HIGH_LATCH: rd_byte = pc_high_latch_reg;
      `PCS_OFS_IRQ_CTRL: rd_byte = irq_ctrl_reg;
      `PCS_OFS_IRQ_CTRL_ALT: rd_byte = irq_ctrl_reg;
      `PCS_OFS_RESET_CAUSE: rd_byte = reset_cause_reg;
      `PCS_OFS_PC_STATUS: rd_byte = {7'h00, irq_request};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h00_0000, rd_byte};
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Program counter and high latch
  // ----------------------------------------
  assign do_push = exec_call || exec_irq_branch;
  // A pop yields to every higher-priority load, so stack and counter agree
  assign do_pop = exec_return && !do_push && !exec_jump;
  assign stk.push = do_push;
  assign stk.pop = do_pop;
  assign stk.push_data = exec_irq_branch ? pc_reg : pc_reg + 13'h0001;

  // High latch is written only by software, never by push or pop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_high_latch_reg <= 8'h00;
    end else if (pc_high_wr) begin
      pc_high_latch_reg <= wr_byte;
    end
  end

  // Priority: irq branch, call/jump, return, software write, advance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_reg <= `PCS_PC_RESET;
    end else if (exec_irq_branch) begin
      pc_reg <= `PCS_IRQ_VECTOR;
    end else if (exec_call || exec_jump) begin
      pc_reg <= {pc_high_latch_reg[4:3], exec_target};
    end else if (exec_return) begin
      pc_reg <= stk.top_data;
    end else if (pc_low_wr) begin
      pc_reg <= {pc_high_latch_reg[4:0], wr_byte};
    end else if (exec_advance) begin
      pc_reg <= pc_reg + 13'h0001;
    end
  end

  assign pc = pc_reg;

  // ----------------------------------------
  // Interrupt control
  // ----------------------------------------
  // Event set wins over a software clear in the same cycle
  always_comb begin
    irq_ctrl_next = irq_ctrl_reg;
    if (irq_wr) begin
      irq_ctrl_next = wr_byte;
    end
    if (irq_sync2_reg) begin
      irq_ctrl_next[`PCS_BIT_TOV_FLAG] = 1'b1;
    end
    if (ext_sync2_reg) begin
      irq_ctrl_next[`PCS_BIT_EXT_FLAG] = 1'b1;
    end
    if (port_sync2_reg) begin
      irq_ctrl_next[`PCS_BIT_PORT_FLAG] = 1'b1;
    end
    if (exec_irq_branch) begin
      irq_ctrl_next[`PCS_BIT_GIE] = 1'b0;
    end else if (exec_return && exec_advance) begin
      irq_ctrl_next[`PCS_BIT_GIE] = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ctrl_reg <= `PCS_IRQ_CTRL_RESET;
    end else begin
      irq_ctrl_reg <= irq_ctrl_next;
    end
  end

  assign irq_request = irq_ctrl_reg[`PCS_BIT_GIE] && (
    (irq_ctrl_reg[`PCS_BIT_TOV_EN] && irq_ctrl_reg[`PCS_BIT_TOV_FLAG]) ||
    (irq_ctrl_reg[`PCS_BIT_EXT_EN] && irq_ctrl_reg[`PCS_BIT_EXT_FLAG]) ||
    (irq_ctrl_reg[`PCS_BIT_PORT_EN] && irq_ctrl_reg[`PCS_BIT_PORT_FLAG]));

  // ----------------------------------------
  // Reset cause
  // ----------------------------------------
  // Power-up marker: only its start value clears it, the bus reset does not
  always_ff @(posedge aclk) begin
    por_done_reg <= 1'b1;
  end

  // Not-POR and not-WDT flags low mean that cause happened, the pin flag high; software writes them to re-arm
  // Requests win over a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!por_done_reg) begin
      reset_cause_reg <= `PCS_RESET_CAUSE_POR;
    end else begin
      if (cause_wr) begin
        reset_cause_reg <= {5'b00000, wr_byte[2:0]};
      end
      if (wdt_sync2_reg) begin
        reset_cause_reg[`PCS_BIT_NOT_WDT] <= 1'b0;
      end
      if (rpin_sync2_reg) begin
        reset_cause_reg[`PCS_BIT_PIN] <= 1'b1;
      end
    end
  end
endmodule

// ---- pcs_regs.svh ----
// Register offsets, field positions and reset values of the program-flow block
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH
// Register indices: the bus byte address is four times the index
`define PCS_OFS_IRQ_CTRL 10'h00B
`define PCS_OFS_IRQ_CTRL_ALT 10'h08B
`define PCS_OFS_RESET_CAUSE 10'h08E
`define PCS_OFS_PC_LOW 10'h002
`define PCS_OFS_PC_HIGH_LATCH 10'h00A
`define PCS_OFS_PC_STATUS 10'h100
`define PCS_BIT_GIE 7
`define PCS_BIT_RSVD 6
`define PCS_BIT_TOV_EN 5
`define PCS_BIT_EXT_EN 4
`define PCS_BIT_PORT_EN 3
`define PCS_BIT_TOV_FLAG 2
`define PCS_BIT_EXT_FLAG 1
`define PCS_BIT_PORT_FLAG 0
`define PCS_BIT_NOT_POR 1
`define PCS_BIT_NOT_WDT 0
`define PCS_BIT_PIN 2
`define PCS_IRQ_CTRL_RESET 8'h00
`define PCS_RESET_CAUSE_POR 8'h01
`define PCS_PC_RESET 13'h0000
`define PCS_IRQ_VECTOR 13'h0004
`endif

// ---- pcs_pkg.sv ----
// Types shared by the program-flow block
package pcs_pkg;
  typedef enum logic [1:0] {
    PCS_RST_POR,
    PCS_RST_PIN,
    PCS_RST_WDT,
    PCS_RST_NONE
  } pcs_rst_src_t;
  typedef enum {
    PCS_WR_IDLE,
    PCS_WR_RESP
  } pcs_wr_state_t;
endpackage

// ---- pcs_stack_if.sv ----
// Push and pop port between the control logic and the return stack
`timescale 1ns/10ps
interface pcs_stack_if #(parameter int AW = 13);
  logic push;
  logic pop;
  logic [AW-1:0] push_data;
  logic [AW-1:0] top_data;
  modport ctrl (output push, output pop, output push_data, input top_data);
  modport stack (input push, input pop, input push_data, output top_data);
endinterface

// ---- pcs_return_stack.sv ----
// Circular return stack with a hidden pointer
`timescale 1ns/10ps
module pcs_return_stack #(
  parameter int DEPTH = 8,
  parameter int AW = 13
) (
  input wire logic aclk,
  input wire logic aresetn,
  pcs_stack_if.stack sp
);
  localparam int PW = $clog2(DEPTH);
  logic [AW-1:0] mem_reg [DEPTH];
  logic [PW-1:0] ptr_reg;

  // ----------------------------------------
  // Pointer
  // ----------------------------------------
  // No counter of depth: wraps silently, no overflow flag exists
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_reg <= '0;
    end else if (sp.push) begin
      ptr_reg <= ptr_reg + 1'b1;
    end else if (sp.pop) begin
      ptr_reg <= ptr_reg - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (sp.push) begin
      mem_reg[ptr_reg] <= sp.push_data;
    end
  end

  assign sp.top_data = mem_reg[ptr_reg - 1'b1];
endmodule

// ---- pcs_flow_monitor.sv ----
// Concurrent checks on the program-flow block ports
`timescale 1ns/10ps
module pcs_flow_monitor (
  input logic aclk,
  input logic aresetn,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic exec_call,
  input logic exec_jump,
  input logic [10:0] exec_target,
  input logic exec_return,
  input logic exec_irq_branch,
  input logic [12:0] pc,
  input logic irq_request
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence call_s;
    exec_call && !exec_irq_branch;
  endsequence
  sequence ret_s;
    exec_return && !exec_call && !exec_jump && !exec_irq_branch;
  endsequence
  sequence idle_s;
    !exec_call && !exec_jump && !exec_return && !exec_irq_branch;
  endsequence
  pc_reset_a: assert property ($rose(aresetn) |-> pc == 13'h0000)
    else $error("pc not clear after reset");
  call_target_a: assert property (call_s |=> pc[10:0] == $past(exec_target))
    else $error("call target not loaded");
  irq_vector_a: assert property (exec_irq_branch |=> pc == 13'h0004 && !irq_request)
    else $error("interrupt branch wrong");
  return_pop_a: assert property (call_s ##1 idle_s ##1 ret_s |=> pc == $past(pc, 3) + 13'h0001)
    else $error("return value not pushed one");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  bresp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after take");
  rresp_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after take");
  cover property (call_s);
  cover property (exec_irq_branch);
  cover property (ret_s);
endmodule
bind pcs_flow_ctrl pcs_flow_monitor i_pcs_flow_monitor (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .exec_call, .exec_jump, .exec_target,
  .exec_return, .exec_irq_branch, .pc, .irq_request);

// ---- pcs_core_model.sv ----
// Decoder stand-in turning an op code into execution strobes
`timescale 1ns/10ps
module pcs_core_model (
  input logic [2:0] op,
  output logic exec_advance,
  output logic exec_call,
  output logic exec_jump,
  output logic exec_return,
  output logic exec_irq_branch
);
  assign exec_call = op == 3'h1;
  assign exec_jump = op == 3'h2;
  assign exec_return = op == 3'h3 || op == 3'h6;
  assign exec_irq_branch = op == 3'h4;
  // Op 6 is the interrupt return, which also re-enables interrupts
  assign exec_advance = op == 3'h5 || op == 3'h6;
endmodule

// ---- pcs_flow_ctrl_tb_top.sv ----
// Self-checking bench for the program-flow block
`timescale 1ns/10ps
`include "pcs_regs.svh"
module pcs_flow_ctrl_tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_request;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic [2:0] op = 3'h0, src = 3'h0;
  logic [1:0] rq = 2'h0;
  logic [10:0] exec_target = 11'h000;
  logic exec_advance, exec_call, exec_jump, exec_return, exec_irq_branch;
  logic [12:0] pc, e;
  logic [12:0] stk [8];
  logic [7:0] lat, d;
  int sp, errors, n_tests, cyc;
  localparam logic [11:0] pcl_a = {`PCS_OFS_PC_LOW, 2'b00};
  localparam logic [11:0] lat_a = {`PCS_OFS_PC_HIGH_LATCH, 2'b00};
  localparam logic [11:0] irq_a = {`PCS_OFS_IRQ_CTRL, 2'b00};
  localparam logic [11:0] irq_alt_a = {`PCS_OFS_IRQ_CTRL_ALT, 2'b00};
  localparam logic [11:0] cause_a = {`PCS_OFS_RESET_CAUSE, 2'b00};
  always #5 aclk = ~aclk;
  pcs_flow_ctrl i_pcs_flow_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .exec_advance, .exec_call, .exec_jump, .exec_target,
    .exec_return, .exec_irq_branch, .timer_zero_overflow(src[2]), .ext_pin_edge(src[1]),
    .port_change(src[0]), .ext_reset_pin_req(rq[1]), .watchdog_timer_req(rq[0]), .pc,
    .irq_request);
  pcs_core_model i_pcs_core_model (.op, .exec_advance, .exec_call, .exec_jump, .exec_return,
    .exec_irq_branch);
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task tally_and_finish;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task cmp_pc(input logic [12:0] g, input logic [12:0] x);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("unexpected pc at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task cmp_reg(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("unexpected data at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task go(input logic [2:0] o, input logic [10:0] t);
    @(posedge aclk);
    op <= o;
    exec_target <= t;
    @(posedge aclk);
    op <= 3'h0;
    #1;
  endtask
  function automatic logic [12:0] far_pc(input logic [7:0] l, input logic [10:0] t);
    return {l[4:3], t};
  endfunction
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 5000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(65272));
    repeat (5) @(posedge aclk);
    #1;
    cmp_pc(pc, 13'h0000);
    @(posedge aclk);
    aresetn <= 1'h1;
    lat = 8'($urandom);
    wr(lat_a, lat);
    rd(lat_a);
    cmp_reg(rd_d, {24'h0, lat});
    d = 8'($urandom);
    wr(pcl_a, d);
    e = {lat[4:0], d};
    cmp_pc(pc, e);
    rd(pcl_a);
    cmp_reg(rd_d, {24'h0, d});
    go(3'h5, 11'h000);
    cmp_pc(pc, e + 13'h0001);
    // Counting past a block end, then a table write takes upper bits from the latch
    wr(pcl_a, 8'hFF);
    go(3'h5, 11'h000);
    cmp_pc(pc, {lat[4:0], 8'hFF} + 13'h0001);
    wr(pcl_a, d);
    cmp_pc(pc, {lat[4:0], d});
    e = far_pc(lat, 11'h7FF);
    go(3'h2, 11'h7FF);
    cmp_pc(pc, e);
    // Nine calls so the ninth wraps onto the first slot
    for (int i = 0; i < 9; i++) begin
      d = 8'($urandom);
      stk[sp] = e + 13'h0001;
      sp = (sp + 1) % 8;
      e = far_pc(lat, {d[2:0], d});
      go(3'h1, {d[2:0], d});
      cmp_pc(pc, e);
    end
    for (int i = 0; i < 9; i++) begin
      sp = (sp + 7) % 8;
      e = stk[sp];
      go(3'h3, 11'h000);
      cmp_pc(pc, e);
    end
    rd(lat_a);
    cmp_reg(rd_d, {24'h0, lat});
    for (int i = 0; i < 3; i++) begin
      wr(irq_alt_a, 8'h38);
      @(posedge aclk);
      src <= 3'h4 >> i;
      @(posedge aclk);
      src <= 3'h0;
      repeat (4) @(posedge aclk);
      rd(irq_a);
      cmp_reg(rd_d, {24'h0, 8'h38 | (8'h04 >> i)});
      cmp_reg({31'h0, irq_request}, 32'h0);
      wr(irq_alt_a, 8'hB8 | (8'h04 >> i));
      cmp_reg({31'h0, irq_request}, 32'h1);
      stk[sp] = e;
      sp = (sp + 1) % 8;
      e = 13'h0004;
      go(3'h4, 11'h000);
      cmp_pc(pc, e);
      sp = (sp + 7) % 8;
      e = stk[sp];
      go(3'h6, 11'h000);
      cmp_pc(pc, e);
      wr(irq_alt_a, 8'h00);
    end
    rd(cause_a);
    cmp_reg(rd_d, {24'h0, `PCS_RESET_CAUSE_POR});
    @(posedge aclk);
    rq <= 2'h3;
    @(posedge aclk);
    rq <= 2'h0;
    repeat (4) @(posedge aclk);
    d = (`PCS_RESET_CAUSE_POR & ~(8'h01 << `PCS_BIT_NOT_WDT)) | (8'h01 << `PCS_BIT_PIN);
    rd(cause_a);
    cmp_reg(rd_d, {24'h0, d});
    wr(cause_a, 8'h03);
    rd(cause_a);
    cmp_reg(rd_d, 32'h0000_0003);
    rd(12'h0F0);
    cmp_reg({30'h0, rd_r}, 32'h2);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    #1;
    cmp_pc(pc, 13'h0000);
    tally_and_finish();
  end
endmodule
